// [bench/spi_link_chk.sv]
// checker: timing relations on the link between controller and device
`timescale 1ns/100ps
`default_nettype none
module spi_link_chk
	import spi_pkg::*;
(
	input wire logic link_clk, // link clock
	input wire logic link_rst, // link reset
	input wire logic clk_en, // clock enable
	input wire logic [9:0] cmd_addr_bus_rise, // rise half
	input wire logic [9:0] cmd_addr_bus_fall, // fall half
	input wire logic [9:0] cmd_addr_bus_oe, // bus drive
	input wire logic [7:0] dq_out, // read data
	input wire logic dq_oe, // data drive
	input wire logic dq_valid // read beat
);
	// 10 us counted in 60 ns boot cycles, rounded up
	localparam int BUSY_MAX = 167;
	logic [7:0] since_rst;
	wire cmd_on = clk_en && (&cmd_addr_bus_oe);
	wire [7:0] cmd_ma = {cmd_addr_bus_rise[9:4], cmd_addr_bus_fall[1:0]};
	wire rd_cmd = cmd_on && cmd_addr_bus_rise[3:0] == CMD_MRR;
	wire rst_cmd = cmd_on && cmd_addr_bus_rise[3:0] == CMD_MRW && cmd_ma == MA_RESET;
	wire bus_idle = cmd_addr_bus_oe == 10'h000;
	// saturates so a long idle run never wraps back below the bound
	always_ff @(posedge link_clk) begin
		if (link_rst || rst_cmd) begin
			since_rst <= 8'h00;
		end else if (since_rst != 8'hff) begin
			since_rst <= since_rst + 8'h01;
		end
	end
	// ********
	// assertions
	// ********
	default clocking @(posedge link_clk); endclocking
	default disable iff (link_rst);
	gate_hiz_a: assert property (!clk_en |-> !dq_oe)
		else $error("data driven with clock enable low");
	valid_drive_a: assert property (dq_valid |-> dq_oe && clk_en)
		else $error("read beat without output drive");
	beat_count_a: assert property ($rose(dq_valid) |-> dq_valid[*4] ##1 !dq_valid)
		else $error("read burst not four beats");
	read_reply_a: assert property (rd_cmd |=> $rose(dq_valid))
		else $error("mode read not answered next cycle");
	oe_whole_a: assert property (bus_idle || (&cmd_addr_bus_oe))
		else $error("command bus partly driven");
	first_idle_a: assert property ($rose(clk_en) |-> bus_idle[*8])
		else $error("command soon after clock enable");
	reset_idle_a: assert property (rst_cmd |=> bus_idle[*8])
		else $error("command soon after reset write");
	init_bound_a: assert property ($rose(dq_valid) && dq_out[0] |-> since_rst < BUSY_MAX)
		else $error("auto init still busy too late");
endmodule
`default_nettype wire

// [bench/tb_top.sv]
// testbench: both ends joined, power-up, reinitialization and power-off
`timescale 1ns/100ps
`default_nettype none
module tb_top;
	import spi_pkg::*;
	logic sys_clk = 1'b0;
	logic rst = 1'b1;
	logic link_rst = 1'b1;
	logic supplies_ok = 1'b0;
	logic start_reset = 1'b0;
	logic power_off = 1'b0;
	logic init_done, slow_clock, auto_init_busy, configured;
	logic [7:0] feature_one_reg, latency_reg, output_drive_reg, calibration_reg;
	logic [3:0] core_beat;
	int err_count = 0;
	int comparisons = 0;
	int n_clk = 0;
	int n_rst = 0;
	time t_ce, t_rst, t_prev;
	bit ce_seen = 0;
	bit done_seen = 0;
	logic [7:0] exp_tab [4] = '{FEATURE_ONE_VAL, LATENCY_VAL, OUTPUT_DRIVE_VAL, CAL_INIT_CODE};
	wire [31:0] regs_seen = {calibration_reg, output_drive_reg, latency_reg, feature_one_reg};
	spi_link_if link();
	spi_ctrl i_spi_ctrl(.sys_clk(sys_clk), .rst(rst), .supplies_ok(supplies_ok),
		.start_reset(start_reset), .power_off(power_off), .link(link.ctrl),
		.init_done(init_done), .slow_clock(slow_clock));
	spi_device i_spi_device(.link(link.dev), .link_rst(link_rst), .auto_init_busy(auto_init_busy),
		.configured(configured), .feature_one_reg(feature_one_reg), .latency_reg(latency_reg),
		.output_drive_reg(output_drive_reg), .calibration_reg(calibration_reg),
		.core_beat(core_beat));
	spi_link_chk i_spi_link_chk(.link_clk(link.link_clk), .link_rst(link_rst),
		.clk_en(link.clk_en), .cmd_addr_bus_rise(link.cmd_addr_bus_rise),
		.cmd_addr_bus_fall(link.cmd_addr_bus_fall), .cmd_addr_bus_oe(link.cmd_addr_bus_oe),
		.dq_out(link.dq_out), .dq_oe(link.dq_oe), .dq_valid(link.dq_valid));
	always #5 sys_clk = ~sys_clk;
	task automatic check(string name, logic [31:0] seen, logic [31:0] exp);
		comparisons++;
		if (seen !== exp) begin
			err_count++;
			$display("CHECK FAILED %s expected %h seen %h", name, exp, seen);
		end
	endtask
	task automatic complete_run();
		if (err_count == 0 && comparisons > 0) begin
			$display("STATUS OK");
		end else begin
			$display("STATUS NOT OK");
		end
		$finish;
	endtask
	// bounded wait, the check after it catches anything longer
	task automatic wait_for(logic v, int lim);
		for (int i = 0; i < lim && init_done !== v; i++) @(negedge sys_clk);
	endtask
	// ********
	// link monitors
	// ********
	always @(posedge link.link_clk) begin
		if (!ce_seen && link.clk_en === 1'b1) begin
			ce_seen = 1'b1;
			t_ce = $time;
			check("clocks before enable", 32'(n_clk >= 5), 1);
		end
		if (!ce_seen) n_clk++;
		if (link.clk_en === 1'b1 && (&link.cmd_addr_bus_oe) === 1'b1
			&& link.cmd_addr_bus_rise[3:0] === CMD_MRW
			&& {link.cmd_addr_bus_rise[9:4], link.cmd_addr_bus_fall[1:0]} === MA_RESET) begin
			n_rst++;
			t_rst = $time;
			done_seen = 0;
			if (n_rst == 1) check("idle span", 32'($time - t_ce >= 200000), 1);
			check("boot period", 32'($time - t_prev >= 18 && $time - t_prev <= 100), 1);
		end
		t_prev = $time;
	end
	// read data launches on the rising edge, so look half a cycle later
	always @(negedge link.link_clk) begin
		if (link.dq_valid === 1'b1) begin
			check("beat marker", 32'($onehot(core_beat)), 1);
		end
		if (link.dq_valid === 1'b1 && link.dq_out[0] === 1'b0 && !done_seen) begin
			done_seen = 1;
			check("auto init span", 32'($time - t_rst <= 10000), 1);
		end
	end
	// ********
	// stimulus
	// ********
	initial begin
		repeat (4) @(negedge sys_clk);
		rst = 1'b0;
		check("enable at reset", link.clk_en, 0);
		check("boot clock at reset", slow_clock, 1);
		check("done at reset", init_done, 0);
		repeat (20) @(negedge sys_clk);
		check("enable before supplies", link.clk_en, 0);
		supplies_ok = 1'b1;
		repeat (9) @(negedge sys_clk);
		check("enable hold", link.clk_en, 0);
		repeat (3) @(negedge link.link_clk);
		link_rst = 1'b0;
		check("output drive after reset", link.dq_oe, 0);
		check("busy after reset", auto_init_busy, 1);
		wait_for(1'b1, 40000);
		check("init done", init_done, 1);
		for (int i = 0; i < 4; i++) begin
			check("config register", regs_seen[8*i +: 8], exp_tab[i]);
		end
		check("configured", configured, 1);
		check("busy after init", auto_init_busy, 0);
		check("boot clock after init", slow_clock, 0);
		check("reset writes", n_rst, 1);
		start_reset = 1'b1;
		@(negedge sys_clk);
		start_reset = 1'b0;
		wait_for(1'b0, 100);
		wait_for(1'b1, 20000);
		check("reset writes again", n_rst, 2);
		check("reinit done", init_done, 1);
		check("reconfigured", configured, 1);
		power_off = 1'b1;
		repeat (20) @(negedge sys_clk);
		check("enable at power off", link.clk_en, 0);
		check("drive at power off", link.dq_oe, 0);
		complete_run();
	end
	initial begin
		#600000;
		err_count++;
		complete_run();
	end
endmodule
`default_nettype wire

// [common/spi_link_if.sv]
// interface: command/address, clock, clock enable and read data between the ends
`timescale 1ns/100ps
`default_nettype none
interface spi_link_if;
	logic link_clk;
	logic clk_en;
	logic [9:0] cmd_addr_bus_rise;
	logic [9:0] cmd_addr_bus_fall;
	logic [9:0] cmd_addr_bus_oe;
	logic [7:0] dq_out;
	logic dq_oe;
	logic dq_valid;
	modport ctrl (output link_clk, clk_en, cmd_addr_bus_rise, cmd_addr_bus_fall,
		cmd_addr_bus_oe, input dq_out, dq_oe, dq_valid);
	modport dev (input link_clk, clk_en, cmd_addr_bus_rise, cmd_addr_bus_fall,
		cmd_addr_bus_oe, output dq_out, dq_oe, dq_valid);
endinterface
`default_nettype wire

// [common/spi_pkg.sv]
// package: constants shared by both ends of the sdram power-up link
`default_nettype none
package spi_pkg;
	localparam int CA_W = 10;
	localparam int DQ_W = 8;
	// command codes carried on the bus, one cycle each (rise half, fall half)
	localparam logic [3:0] CMD_IDLE = 4'h0;
	localparam logic [3:0] CMD_MRW = 4'h1;
	localparam logic [3:0] CMD_MRR = 4'h2;
	localparam logic [3:0] CMD_PRE_ALL = 4'h3;
	localparam logic [3:0] CMD_PD_ENTRY = 4'h4;
	localparam logic [3:0] CMD_PD_EXIT = 4'h5;
	localparam logic [3:0] CMD_ACT = 4'h6;
	localparam logic [3:0] CMD_RD = 4'h7;
	localparam logic [3:0] CMD_WR = 4'h8;
	// mode register addresses
	localparam logic [7:0] MA_DEVICE_INFO = 8'h00;
	localparam logic [7:0] MA_FEATURE_ONE = 8'h01;
	localparam logic [7:0] MA_LATENCY = 8'h02;
	localparam logic [7:0] MA_OUTPUT_DRIVE = 8'h03;
	localparam logic [7:0] MA_CALIBRATION = 8'h0a;
	localparam logic [7:0] MA_RESET = 8'h3f;
	localparam int AUTO_INIT_BIT = 0;
	// configuration values written at boot
	localparam logic [7:0] FEATURE_ONE_VAL = 8'h42;
	localparam logic [7:0] LATENCY_VAL = 8'h04;
	localparam logic [7:0] OUTPUT_DRIVE_VAL = 8'h02;
	localparam logic [7:0] CAL_INIT_CODE = 8'hff;
	// timing, in their own units
	localparam int GATE_LOW_HOLD_NS = 100;
	localparam int CLOCK_STABLE_CK = 5;
	localparam int FIRST_IDLE_US = 200;
	localparam int POST_RESET_IDLE_US = 1;
	localparam int AUTO_INIT_MAX_US = 10;
	localparam int INITIAL_CAL_US = 1;
	localparam int BOOT_CLOCK_MIN_NS = 18;
	localparam int BOOT_CLOCK_MAX_NS = 100;
	localparam int SYS_PERIOD_NS = 10;
	localparam int LINK_PERIOD_NS = 48;
	// controller cycle counts (least times round up)
	localparam int GATE_LOW_HOLD_CYC = (GATE_LOW_HOLD_NS + SYS_PERIOD_NS - 1) / SYS_PERIOD_NS;
	localparam int FIRST_IDLE_CYC = (FIRST_IDLE_US * 1000 + SYS_PERIOD_NS - 1) / SYS_PERIOD_NS;
	localparam int POST_RESET_IDLE_CYC = (POST_RESET_IDLE_US * 1000 + SYS_PERIOD_NS - 1)
		/ SYS_PERIOD_NS;
	localparam int INITIAL_CAL_CYC = (INITIAL_CAL_US * 1000 + SYS_PERIOD_NS - 1) / SYS_PERIOD_NS;
	localparam int AUTO_INIT_MAX_CYC = (AUTO_INIT_MAX_US * 1000) / SYS_PERIOD_NS;
	// boot clock: divider half period in sys cycles, giving 60 ns (inside 18..100)
	localparam int BOOT_HALF_DIV = 3;
	localparam int RUN_HALF_DIV = 3;
	// device: auto-init length in link cycles, below the maximum (rounded down)
	localparam int DEV_AUTO_INIT_CYC = (AUTO_INIT_MAX_US * 1000) / LINK_PERIOD_NS / 2;
	localparam int DEV_POST_RESET_CYC = (POST_RESET_IDLE_US * 1000) / LINK_PERIOD_NS;
	typedef enum logic [1:0] {DEV_OFF_type_x} spi_unused_type;
endpackage
`default_nettype wire

// [src/spi_ctrl.sv]
// module: memory controller end, drives the power-up sequence
`timescale 1ns/100ps
`default_nettype none
module spi_ctrl
	import spi_pkg::*;
(
	input wire logic sys_clk, // controller clock
	input wire logic rst, // synchronous reset
	input wire logic supplies_ok, // all supplies within range (pin)
	input wire logic start_reset, // request a reinitialization (pulse)
	input wire logic power_off, // hold for power-off (level)
	spi_link_if.ctrl link, // link to the device
	output logic init_done, // sequence complete
	output logic slow_clock // boot clock selected
);
	import spi_pkg::*;

	typedef enum logic [3:0] {C_OFF, C_HOLD_LOW, C_IDLE1, C_RESET, C_POST_RESET, C_POLL,
		C_POLL_WAIT, C_CAL, C_CAL_WAIT, C_CFG, C_DONE} spi_ctrl_state_type;

	// ************
	// input synchronisers
	// ************
	logic sup_m, sup_s, rd_m, rd_s, rdv_m, rdv_s, off_m, off_s;
	always_ff @(posedge sys_clk) begin
		sup_m <= supplies_ok;
		sup_s <= sup_m;
		off_m <= power_off;
		off_s <= off_m;
		rd_m <= link.dq_out[AUTO_INIT_BIT];
		rd_s <= rd_m;
		rdv_m <= link.dq_valid;
		rdv_s <= rdv_m;
	end

	// ************
	// clock divider and command launch
	// ************
	spi_ctrl_state_type state;
	logic [7:0] div_cnt;
	logic [31:0] wait_cnt;
	logic [1:0] cfg_idx;
	logic [3:0] cmd;
	logic [7:0] ma, op;
	logic fall_edge, link_ck;
	logic [7:0] half_div;
	// boot clock for all reads before configuration
	assign half_div = slow_clock ? 8'(BOOT_HALF_DIV) : 8'(RUN_HALF_DIV);
	assign fall_edge = link_ck && div_cnt == half_div - 8'h01;
	always_ff @(posedge sys_clk) begin
		if (rst) begin
			div_cnt <= 8'h00;
			link_ck <= 1'b0;
		end else if (div_cnt == half_div - 8'h01) begin
			div_cnt <= 8'h00;
			link_ck <= !link_ck;
		end else begin
			div_cnt <= div_cnt + 8'h01;
		end
	end
	assign link.link_clk = link_ck;

	// commands change only at link falling edge so the device sees them stable
	always_ff @(posedge sys_clk) begin
		if (rst) begin
			link.cmd_addr_bus_rise <= 10'h000;
			link.cmd_addr_bus_fall <= 10'h000;
			link.cmd_addr_bus_oe <= 10'h000;
		end else if (fall_edge) begin
			link.cmd_addr_bus_rise <= {ma[7:2], cmd};
			link.cmd_addr_bus_fall <= {op, ma[1:0]};
			link.cmd_addr_bus_oe <= (cmd == CMD_IDLE) ? 10'h000 : 10'h3ff;
		end
	end

	// ************
	// sequencer
	// ************
	always_comb begin
		cmd = CMD_IDLE;
		ma = 8'h00;
		op = 8'h00;
		case (state)
		C_RESET: begin
			cmd = CMD_MRW;
			ma = MA_RESET;
		end
		C_POLL: begin
			cmd = CMD_MRR;
			ma = MA_DEVICE_INFO;
		end
		C_CAL: begin
			cmd = CMD_MRW;
			ma = MA_CALIBRATION;
			op = CAL_INIT_CODE;
		end
		C_CFG: begin
			cmd = CMD_MRW;
			ma = (cfg_idx == 2'h0) ? MA_FEATURE_ONE : (cfg_idx == 2'h1) ? MA_LATENCY
				: MA_OUTPUT_DRIVE;
			op = (cfg_idx == 2'h0) ? FEATURE_ONE_VAL : (cfg_idx == 2'h1) ? LATENCY_VAL
				: OUTPUT_DRIVE_VAL;
		end
		// no row access is ever launched here, so no activate is owed
		default: cmd = CMD_IDLE;
		endcase
	end

	always_ff @(posedge sys_clk) begin
		if (rst || off_s) begin
			state <= C_OFF;
			link.clk_en <= 1'b0;
			wait_cnt <= 32'h0;
			cfg_idx <= 2'h0;
			init_done <= 1'b0;
			slow_clock <= 1'b1;
		end else begin
			wait_cnt <= wait_cnt + 32'h1;
			case (state)
			C_OFF: begin
				wait_cnt <= 32'h0;
				if (sup_s) begin
					state <= C_HOLD_LOW;
				end
			end
			C_HOLD_LOW: begin
				// long enough also covers five stable link clocks
				if (wait_cnt >= 32'(GATE_LOW_HOLD_CYC + CLOCK_STABLE_CK * 2 * BOOT_HALF_DIV)
						&& fall_edge) begin
					link.clk_en <= 1'b1;
					wait_cnt <= 32'h0;
					state <= C_IDLE1;
				end
			end
			C_IDLE1: begin
				if (wait_cnt >= 32'(FIRST_IDLE_CYC) && fall_edge) begin
					state <= C_RESET;
				end
			end
			C_RESET: begin
				if (fall_edge) begin
					wait_cnt <= 32'h0;
					init_done <= 1'b0;
					slow_clock <= 1'b1;
					state <= C_POST_RESET;
				end
			end
			C_POST_RESET: begin
				if (wait_cnt >= 32'(POST_RESET_IDLE_CYC) && fall_edge) begin
					state <= C_POLL;
				end
			end
			C_POLL: begin
				if (fall_edge) begin
					state <= C_POLL_WAIT;
				end
			end
			C_POLL_WAIT: begin
				if (wait_cnt >= 32'(AUTO_INIT_MAX_CYC) && fall_edge) begin
					state <= C_CAL;
				end else if (rdv_s && !rd_s && fall_edge) begin
					state <= C_CAL;
				end else if (wait_cnt[6:0] == 7'h7f && fall_edge) begin
					state <= C_POLL;
				end
			end
			C_CAL: begin
				if (fall_edge) begin
					wait_cnt <= 32'h0;
					state <= C_CAL_WAIT;
				end
			end
			C_CAL_WAIT: begin
				if (wait_cnt >= 32'(INITIAL_CAL_CYC) && fall_edge) begin
					state <= C_CFG;
				end
			end
			C_CFG: begin
				if (fall_edge) begin
					cfg_idx <= cfg_idx + 2'h1;
					if (cfg_idx == 2'h2) begin
						state <= C_DONE;
					end
				end
			end
			C_DONE: begin
				// done only once the last write has stood through a link rise
				if (fall_edge) begin
					init_done <= 1'b1;
					slow_clock <= 1'b0;
				end
				if (start_reset) begin
					cfg_idx <= 2'h0;
					state <= C_RESET;
				end
			end
			default: state <= C_OFF;
			endcase
		end
	end
endmodule
`default_nettype wire

// [src/spi_device.sv]
// module: memory device end, power-up and reset sequencing
`timescale 1ns/100ps
`default_nettype none
module spi_device
	import spi_pkg::*;
(
	spi_link_if.dev link, // link side, clocked by link.link_clk
	input wire logic link_rst, // synchronous reset on the link clock
	output logic auto_init_busy, // status bit as held by the device
	output logic configured, // set once the output drive register is written
	output logic [7:0] feature_one_reg, // latest feature value
	output logic [7:0] latency_reg, // latest latency value
	output logic [7:0] output_drive_reg, // latest drive value
	output logic [7:0] calibration_reg, // latest calibration code
	output logic [3:0] core_beat // one-hot beat marker of a four-beat transfer
);
	import spi_pkg::*;

	typedef enum logic [2:0] {ST_POWER, ST_WAIT_RESET, ST_POST_RESET, ST_AUTO_INIT,
		ST_IDLE} spi_dev_state_type;

	// ************
	// command decode
	// ************
	spi_dev_state_type state;
	logic [15:0] wait_cnt;
	logic [1:0] beat;
	logic [3:0] cmd;
	logic [7:0] ma;
	logic [7:0] op;
	logic is_mrw, is_mrr, is_reset, gated_ok, rd_busy;
	// undriven bits read as idle
	assign cmd = (link.cmd_addr_bus_oe[3:0] == 4'hf) ? link.cmd_addr_bus_rise[3:0] : CMD_IDLE;
	assign ma = {link.cmd_addr_bus_rise[9:4], link.cmd_addr_bus_fall[1:0]};
	assign op = link.cmd_addr_bus_fall[9:2];
	assign is_mrw = link.clk_en && cmd == CMD_MRW;
	assign is_mrr = link.clk_en && cmd == CMD_MRR;
	assign is_reset = is_mrw && ma == MA_RESET;
	// until auto-init ends only reads, power-down commands and the reset write are taken; the
	// post-reset count is in link cycles of unknown period, so reads are taken from it on
	assign gated_ok = (state == ST_IDLE) || ((state == ST_AUTO_INIT
		|| state == ST_POST_RESET) && (cmd == CMD_MRR || cmd == CMD_PD_ENTRY
		|| cmd == CMD_PD_EXIT));

	// ************
	// sequencing
	// ************
	always_ff @(posedge link.link_clk) begin
		if (link_rst) begin
			state <= ST_POWER;
			wait_cnt <= 16'h0000;
			auto_init_busy <= 1'b1;
		end else if (is_reset) begin
			state <= ST_POST_RESET;
			wait_cnt <= 16'h0000;
			auto_init_busy <= 1'b1;
		end else begin
			case (state)
			ST_POWER: begin
				if (link.clk_en) begin
					state <= ST_WAIT_RESET;
				end
			end
			ST_WAIT_RESET: begin
				state <= ST_WAIT_RESET;
			end
			ST_POST_RESET: begin
				wait_cnt <= wait_cnt + 16'h0001;
				if (wait_cnt >= 16'(DEV_POST_RESET_CYC)) begin
					state <= ST_AUTO_INIT;
				end
			end
			ST_AUTO_INIT: begin
				wait_cnt <= wait_cnt + 16'h0001;
				// finished well inside the ten-microsecond ceiling
				if (wait_cnt >= 16'(DEV_POST_RESET_CYC + DEV_AUTO_INIT_CYC)) begin
					state <= ST_IDLE;
					auto_init_busy <= 1'b0;
				end
			end
			ST_IDLE: begin
				state <= ST_IDLE;
			end
			default: begin
				state <= ST_POWER;
			end
			endcase
		end
	end

	// ************
	// mode registers
	// ************
	always_ff @(posedge link.link_clk) begin
		if (link_rst || is_reset) begin
			feature_one_reg <= 8'h00;
			latency_reg <= 8'h00;
			output_drive_reg <= 8'h00;
			calibration_reg <= 8'h00;
			configured <= 1'b0;
		end else if (is_mrw && gated_ok) begin
			case (ma)
			MA_FEATURE_ONE: feature_one_reg <= op;
			MA_LATENCY: latency_reg <= op;
			MA_OUTPUT_DRIVE: begin
				output_drive_reg <= op;
				configured <= 1'b1;
			end
			MA_CALIBRATION: calibration_reg <= op;
			default: configured <= configured; // writes to read-only addresses ignored
			endcase
		end
	end

	// ************
	// read data path
	// ************
	// a read answers as four full-cycle beats of one core word
	assign rd_busy = beat != 2'b00;
	always_ff @(posedge link.link_clk) begin
		if (link_rst || !link.clk_en) begin
			link.dq_oe <= 1'b0;
			link.dq_valid <= 1'b0;
			link.dq_out <= 8'h00;
			beat <= 2'b00;
			core_beat <= 4'h0;
		end else if (is_mrr && gated_ok && !rd_busy) begin
			link.dq_oe <= 1'b1;
			link.dq_valid <= 1'b1;
			link.dq_out <= (ma == MA_DEVICE_INFO) ? {7'h00, auto_init_busy} : 8'h00;
			beat <= 2'b01;
			core_beat <= 4'h1;
		end else if (rd_busy) begin
			beat <= beat + 2'b01;
			core_beat <= {core_beat[2:0], 1'b0};
			// the fourth beat stands a full cycle too; the idle branch ends it
			link.dq_oe <= 1'b1;
			link.dq_valid <= 1'b1;
		end else begin
			link.dq_oe <= 1'b0;
			link.dq_valid <= 1'b0;
			core_beat <= 4'h0;
		end
	end
endmodule
`default_nettype wire
